//--- irq_out_pkg.sv
// constants for the rtc interrupt output logic
package irq_out_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR    = 8'h00;
    localparam logic [7:0] FLAGS_ADDR   = 8'h04;
    localparam logic [7:0] STATUS_ADDR  = 8'h08;
    localparam logic [7:0] CDVAL_ADDR   = 8'h0C;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_FAST_TICK  = 0;
    localparam int CTL_SLOW_TICK  = 1;
    localparam int CTL_CD_IE      = 2;
    localparam int CTL_WD_LO      = 3;
    localparam int CTL_ALARM_IE   = 5;
    localparam int CTL_CAP_IE     = 6;
    localparam int CTL_SWO_IE     = 7;
    localparam int CTL_LOWBAT_IE  = 8;
    localparam int CTL_PULSE_SEL  = 9;
    localparam int CTL_CAP_ON_SWO = 10;
    localparam int CTL_CD_SRC_LO  = 11;
    localparam logic [12:0] CTRL_RESET = 13'h0000;

    // ------------------------------------------------------------
    // flag register fields (write one to clear; watchdog and low-battery are read only)
    // ------------------------------------------------------------
    localparam int FLG_TICK   = 0;
    localparam int FLG_CD     = 1;
    localparam int FLG_ALARM  = 2;
    localparam int FLG_CAP    = 3;
    localparam int FLG_SWO    = 5;
    localparam int FLG_WD     = 6;
    localparam int FLG_LOWBAT = 7;

    // ------------------------------------------------------------
    // countdown source clock select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_4096 = 2'h0;
    localparam logic [1:0] SRC_64   = 2'h1;
    localparam logic [1:0] SRC_1    = 2'h2;
    localparam logic [1:0] SRC_1_60 = 2'h3;

    // ------------------------------------------------------------
    // timing: 40 MHz clock, pulse widths in Hz (width = 1/x s)
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 40000000;
    localparam int PW_64_HZ     = 64;
    localparam int PW_128_HZ    = 128;
    localparam int PW_4096_HZ   = 4096;
    localparam int PW_8192_HZ   = 8192;
    localparam int CYC_64       = CLK_HZ / PW_64_HZ;
    localparam int CYC_128      = CLK_HZ / PW_128_HZ;
    localparam int CYC_4096     = CLK_HZ / PW_4096_HZ;
    localparam int CYC_8192     = CLK_HZ / PW_8192_HZ;
    localparam int PW_W         = 20;

endpackage

//--- rtc_irq_out.sv
// interrupt merge, pulse shaping and switch-over timestamp capture for the rtc
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Notes on behaviour
// [RL1] capture-on-switchover off: switch-over leaves timestamp untouched.
// [RL2] capture on, flag clear: switch-over loads timestamp and sets switchover flag in the same cycle.
// [RL3] capture on, flag set: timestamp frozen, switch-over and tamper edges ignored.
// [RL4] request line active low open drain, released when all sources disabled.
// [RL5] pulse select affects tick and countdown only; others are levels.
// [RL6] tick, countdown, alarm, capture and switch-over flags cleared by write.
// [RL7] watchdog and low-battery flags read only; low-battery follows detector.
// [RL8] tick flag sets on minute with slow enable, on second with fast.
// [RL9] tick: pulse when pulse select is 1, level until cleared otherwise.
// [RL10] tick pulse lasts one sixty-fourth of a second.
// [RL11] countdown enable gates countdown; pulse per period or level on flag.
// [RL12] countdown pulse width set by source clock and loaded value.
// [RL13] loaded countdown value zero stops timer, no pulses.
// [RL14] clearing tick or countdown flag ends a running pulse at once.
// [RL15] watchdog control gates watchdog level, drops only when flag resets.
// [RL16] alarm enable: request follows alarm flag as level.
// [RL17] capture enable: request follows capture flags as level.
// [RL18] switch-over enable: request follows switch-over flag as level.
// [RL19] low-battery enable: request follows low-battery flag.
// [RL20] request is the OR of all enabled sources.
// ------------------------------------------------------------
module rtc_irq_out
    import irq_out_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // time base events (one-cycle pulses; tamper and low-battery inputs are levels)
    input  wire logic        sec_inc,
    input  wire logic        min_inc,
    input  wire logic        cd_period,
    input  wire logic        alarm_event,
    input  wire logic        watchdog_expire,
    input  wire logic        watchdog_restart,
    input  wire logic        switchover_event,
    input  wire logic        tamper_in_n,
    input  wire logic        low_battery_detect,
    // current time and date
    input  wire logic [47:0] time_now,
    // captured timestamp
    output logic      [47:0] timestamp,
    // open-drain request line
    output logic             irq_out,
    output logic             irq_oe
);

    typedef struct packed {
        logic [12:0] ctrl;
        logic [7:0]  cd_value;
        logic        tick_flag;
        logic        countdown_flag;
        logic        alarm_flag;
        logic [1:0]  capture_flags;
        logic        switchover_flag;
        logic        watchdog_flag;
        logic        low_battery_flag;
        logic        tamper_d;
        logic        tick_pulse;
        logic [PW_W-1:0] tick_cnt;
        logic        cd_pulse;
        logic [PW_W-1:0] cd_cnt;
        logic [47:0] timestamp;
        logic [15:0] rdata;
        logic        irq_oe;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // pulse length in cycles for a countdown pulse
    function automatic logic [PW_W-1:0] cd_width(input logic [1:0] src, input logic [7:0] n);
        logic [PW_W-1:0] w;
        w = PW_W'(CYC_64);
        case (src)
            SRC_4096: w = (n == 8'h01) ? PW_W'(CYC_8192) : PW_W'(CYC_4096);
            SRC_64:   w = (n == 8'h01) ? PW_W'(CYC_128) : PW_W'(CYC_64);
            default:  w = PW_W'(CYC_64);
        endcase
        return w;
    endfunction

    logic tick_event;
    logic cd_event;
    logic tamper_fall;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_cdval;
    logic [15:0] clr;
    logic tick_clr;
    logic cd_clr;
    logic tick_src;
    logic cd_src;
    logic wd_en;
    logic any_req;

    always_comb begin
        s_nxt = s_r;
        wr_ctrl  = reg_wr && (reg_addr == CTRL_ADDR);
        wr_flags = reg_wr && (reg_addr == FLAGS_ADDR);
        wr_cdval = reg_wr && (reg_addr == CDVAL_ADDR);
        clr = wr_flags ? reg_wdata : 16'h0000;
        tick_clr = clr[FLG_TICK];
        cd_clr   = clr[FLG_CD];

        // ------------------------------------------------------------
        // control and countdown value
        // ------------------------------------------------------------
        if (wr_ctrl) begin
            s_nxt.ctrl = reg_wdata[12:0];
        end
        if (wr_cdval) begin
            s_nxt.cd_value = reg_wdata[7:0];
        end

        // ------------------------------------------------------------
        // event sources
        // ------------------------------------------------------------
        tick_event = s_r.ctrl[CTL_FAST_TICK] ? sec_inc                 // RL8
                   : (s_r.ctrl[CTL_SLOW_TICK] && min_inc);            // RL8
        cd_event = cd_period && (s_r.cd_value != 8'h00);              // RL13
        s_nxt.tamper_d = tamper_in_n;
        tamper_fall = s_r.tamper_d && !tamper_in_n;

        // ------------------------------------------------------------
        // flags: set wins over clear
        // ------------------------------------------------------------
        if (tick_clr) s_nxt.tick_flag = 1'b0;                         // RL6
        if (tick_event) s_nxt.tick_flag = 1'b1;
        if (cd_clr) s_nxt.countdown_flag = 1'b0;                      // RL6
        if (cd_event) s_nxt.countdown_flag = 1'b1;
        if (clr[FLG_ALARM]) s_nxt.alarm_flag = 1'b0;                  // RL6
        if (alarm_event) s_nxt.alarm_flag = 1'b1;
        s_nxt.capture_flags = s_r.capture_flags & ~clr[FLG_CAP+1:FLG_CAP]; // RL6
        if (clr[FLG_SWO]) s_nxt.switchover_flag = 1'b0;               // RL6

        // read-only flags, no software clear path
        if (watchdog_restart) s_nxt.watchdog_flag = 1'b0;             // RL7
        if (watchdog_expire) s_nxt.watchdog_flag = 1'b1;              // RL7
        s_nxt.low_battery_flag = low_battery_detect;                  // RL7

        // ------------------------------------------------------------
        // switch-over and tamper timestamp capture
        // ------------------------------------------------------------
        if (s_r.ctrl[CTL_CAP_ON_SWO] && s_r.switchover_flag) begin
            // frozen until the switch-over flag is cleared             
        end else begin                                                // RL3
            if (switchover_event && s_r.ctrl[CTL_CAP_ON_SWO]) begin
                s_nxt.timestamp = time_now;                           // RL2
                s_nxt.switchover_flag = 1'b1;                         // RL2
                s_nxt.capture_flags[1] = 1'b1;
            end else if (tamper_fall) begin
                s_nxt.timestamp = time_now;
                s_nxt.capture_flags[0] = 1'b1;
            end
            if (switchover_event && !s_r.ctrl[CTL_CAP_ON_SWO]) begin
                s_nxt.switchover_flag = 1'b1;                         // RL1
            end
        end

        // ------------------------------------------------------------
        // pulse generators
        // ------------------------------------------------------------
        if (s_r.tick_pulse) begin
            if (s_r.tick_cnt <= PW_W'(1) || tick_clr) begin           // RL14
                s_nxt.tick_pulse = 1'b0;
                s_nxt.tick_cnt = '0;
            end else begin
                s_nxt.tick_cnt = s_r.tick_cnt - PW_W'(1);
            end
        end
        if (tick_event) begin
            s_nxt.tick_pulse = 1'b1;
            s_nxt.tick_cnt = PW_W'(CYC_64);                           // RL10
        end
        if (s_r.cd_pulse) begin
            if (s_r.cd_cnt <= PW_W'(1) || cd_clr) begin               // RL14
                s_nxt.cd_pulse = 1'b0;
                s_nxt.cd_cnt = '0;
            end else begin
                s_nxt.cd_cnt = s_r.cd_cnt - PW_W'(1);
            end
        end
        if (cd_event) begin
            s_nxt.cd_pulse = 1'b1;
            s_nxt.cd_cnt = cd_width(s_r.ctrl[CTL_CD_SRC_LO+:2], s_r.cd_value); // RL12
        end

        // ------------------------------------------------------------
        // request merge onto the open-drain line
        // ------------------------------------------------------------
        tick_src = (s_r.ctrl[CTL_FAST_TICK] || s_r.ctrl[CTL_SLOW_TICK]) // RL4
                 && (s_r.ctrl[CTL_PULSE_SEL] ? s_nxt.tick_pulse       // RL9
                 : s_nxt.tick_flag);                                  // RL5
        cd_src = s_r.ctrl[CTL_CD_IE]                                  // RL11
               && (s_r.ctrl[CTL_PULSE_SEL] ? s_nxt.cd_pulse : s_nxt.countdown_flag);
        wd_en = s_r.ctrl[CTL_WD_LO+:2] != 2'h0;
        any_req = tick_src || cd_src                                  // RL20
                || (wd_en && s_nxt.watchdog_flag)                     // RL15
                || (s_r.ctrl[CTL_ALARM_IE] && s_nxt.alarm_flag)       // RL16
                || (s_r.ctrl[CTL_CAP_IE] && (s_nxt.capture_flags != 2'h0)) // RL17
                || (s_r.ctrl[CTL_SWO_IE] && s_nxt.switchover_flag)    // RL18
                || (s_r.ctrl[CTL_LOWBAT_IE] && s_nxt.low_battery_flag); // RL19
        s_nxt.irq_oe = any_req;                                       // RL4

        // ------------------------------------------------------------
        // read data, valid the cycle after the strobe
        // ------------------------------------------------------------
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                CTRL_ADDR:   s_nxt.rdata = {3'h0, s_r.ctrl};
                FLAGS_ADDR:  s_nxt.rdata = {8'h00, s_r.low_battery_flag, s_r.watchdog_flag,
                                            s_r.switchover_flag, s_r.capture_flags,
                                            s_r.alarm_flag, s_r.countdown_flag,
                                            s_r.tick_flag};
                STATUS_ADDR: s_nxt.rdata = {14'h0000, s_r.cd_pulse, s_r.tick_pulse};
                CDVAL_ADDR:  s_nxt.rdata = {8'h00, s_r.cd_value};
                default:     s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RESET;
            s_r.tamper_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign timestamp = s_r.timestamp;
    assign irq_out   = 1'b0;
    assign irq_oe    = s_r.irq_oe;

endmodule

//--- rtc_irq_out_sva.sv
// assertion checker for the rtc interrupt output logic
`timescale 1ns/1ps
module rtc_irq_out_sva
    import irq_out_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    // events
    input wire logic        sec_inc,
    input wire logic        min_inc,
    input wire logic        alarm_event,
    input wire logic        watchdog_restart,
    input wire logic        switchover_event,
    input wire logic        tamper_in_n,
    input wire logic        low_battery_detect,
    // time and request
    input wire logic [47:0] time_now,
    input wire logic [47:0] timestamp,
    input wire logic        irq_oe
);
    logic [12:0] ctrl_r;
    logic        swo_r;
    logic        fwr;
    assign fwr = reg_wr && (reg_addr == FLAGS_ADDR);
    // shadow copies of the control word and the switch-over flag
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_r <= 13'h0000;
            swo_r  <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == CTRL_ADDR)) ctrl_r <= reg_wdata[12:0];
            if (switchover_event && !(ctrl_r[CTL_CAP_ON_SWO] && swo_r)) swo_r <= 1'b1;
            else if (fwr && reg_wdata[FLG_SWO]) swo_r <= 1'b0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence calm_s;
        tamper_in_n [*3];
    endsequence
    sequence only_wdog_s;
        (((ctrl_r[8:0] & 9'h1E7) == 9'h000) && !reg_wr) [*2];
    endsequence
    quiet_off_a: assert property ((ctrl_r[8:0] == 9'h000) [*2] |-> !irq_oe)
        else $error("request driven with every source off");
    fast_tick_a: assert property (sec_inc && ctrl_r[CTL_FAST_TICK] |=> irq_oe)
        else $error("no request after second tick");
    clear_cut_a: assert property (fwr && reg_wdata[FLG_TICK] && !sec_inc && !min_inc
        && (ctrl_r[8:2] == 7'h00) |=> !irq_oe) else $error("tick request not cut by clear");
    wdog_level_a: assert property (only_wdog_s ##0 (irq_oe && !watchdog_restart)
        |=> irq_oe) else $error("watchdog request dropped early");
    alarm_follow_a: assert property (alarm_event && ctrl_r[CTL_ALARM_IE] |=> irq_oe)
        else $error("no request after alarm");
    swo_follow_a: assert property (switchover_event && ctrl_r[CTL_SWO_IE]
        && !(ctrl_r[CTL_CAP_ON_SWO] && swo_r && fwr && reg_wdata[FLG_SWO]) |=> irq_oe)
        else $error("no request after switch-over");
    lowbat_follow_a: assert property ((low_battery_detect && ctrl_r[CTL_LOWBAT_IE]) [*2]
        |=> irq_oe) else $error("no request on low battery");
    cap_off_a: assert property (calm_s ##0 (switchover_event && !ctrl_r[CTL_CAP_ON_SWO])
        |=> $stable(timestamp)) else $error("timestamp changed with capture off");
    cap_load_a: assert property (switchover_event && ctrl_r[CTL_CAP_ON_SWO] && !swo_r
        |=> timestamp == $past(time_now)) else $error("timestamp not loaded");
    cap_hold_a: assert property (calm_s ##0 (switchover_event && ctrl_r[CTL_CAP_ON_SWO]
        && swo_r) |=> $stable(timestamp)) else $error("timestamp overwritten");
endmodule

//--- irq_host_model.sv
// host side of the open-drain request line with its pull-up
`timescale 1ns/1ps
module irq_host_model (
    // request pins of the block
    input  wire logic irq_out,
    input  wire logic irq_oe,
    // line level seen by the host
    output logic      irq_line_n
);
    // a released line floats up to the pull-up level
    assign irq_line_n = irq_oe ? irq_out : 1'b1;
endmodule

//--- rtc_irq_out_test.sv
// self-checking bench for the rtc interrupt output logic
`timescale 1ns/1ps
module rtc_irq_out_test
    import irq_out_pkg::*;
;
    logic        ref_clk     = 1'b0;
    logic        srst        = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [15:0] reg_wdata   = 16'h0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [6:0]  ev          = 7'h00;
    logic        tamper_in_n = 1'b1;
    logic        lbd         = 1'b0;
    logic [47:0] time_now    = 48'hA1B2C3D4E5F6;
    logic [15:0] reg_rdata;
    logic [47:0] timestamp;
    logic        irq_out;
    logic        irq_oe;
    logic        irq_line_n;
    int          miscompares = 0;
    int          check_count = 0;
    localparam logic [15:0] CTL_TAB [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0020, 16'h0080};
    localparam int          EV_TAB  [5] = '{0, 1, 2, 3, 6};
    localparam int          FLG_TAB [5] = '{FLG_TICK, FLG_TICK, FLG_CD, FLG_ALARM, FLG_SWO};
    always #12.5 ref_clk = ~ref_clk;
    rtc_irq_out i_rtc_irq_out (
        .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sec_inc(ev[0]), .min_inc(ev[1]), .cd_period(ev[2]), .alarm_event(ev[3]),
        .watchdog_expire(ev[4]), .watchdog_restart(ev[5]), .switchover_event(ev[6]),
        .tamper_in_n, .low_battery_detect(lbd), .time_now, .timestamp, .irq_out, .irq_oe
    );
    irq_host_model i_irq_host_model (.irq_out, .irq_oe, .irq_line_n);
    task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk("read data", 48'(reg_rdata), 48'(e));
    endtask
    task automatic pulse(int b);
        @(posedge ref_clk);
        ev[b] <= 1'b1;
        @(posedge ref_clk);
        ev[b] <= 1'b0;
    endtask
    task automatic see(logic e);
        @(posedge ref_clk);
        #1 chk("request line", 48'(irq_line_n), 48'(e));
    endtask
    task automatic clr(logic [15:0] m, logic e);
        wr(FLAGS_ADDR, m);
        see(e);
    endtask
    task automatic tamper();
        @(posedge ref_clk);
        tamper_in_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        tamper_in_n <= 1'b1;
    endtask
    // counts the cycles in which the line is pulled low, starting right after the event
    task automatic width(int lim, int exp);
        int n;
        n = 0;
        for (int k = 0; k < lim; k++) begin
            #1 if (irq_line_n === 1'b0) n++;
            @(posedge ref_clk);
        end
        chk("pulse width", 48'(n), 48'(exp));
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        wr(8'h10, 16'hFFFF);
        rd(8'h10, 16'h0000);
        rd(CTRL_ADDR, 16'h0000);
        see(1'b1);
        wr(CDVAL_ADDR, 16'h0000);
        wr(CTRL_ADDR, 16'h0004);
        pulse(2);
        see(1'b1);
        wr(CDVAL_ADDR, 16'h0005);
        wr(CTRL_ADDR, 16'h0002);
        pulse(0);
        see(1'b1);
        rd(FLAGS_ADDR, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_ADDR, CTL_TAB[i]);
            pulse(EV_TAB[i]);
            see(1'b0);
            see(1'b0);
            rd(FLAGS_ADDR, 16'h0001 << FLG_TAB[i]);
            clr(16'h0001 << FLG_TAB[i], 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            wr(CTRL_ADDR, (i == 0) ? 16'h0201 : 16'h0204);
            pulse(i * 2);
            see(1'b0);
            rd(STATUS_ADDR, 16'h0001 << i);
            clr(16'h0001 << i, 1'b1);
        end
        wr(CDVAL_ADDR, 16'h0001);
        pulse(2);
        width(6000, CYC_8192);
        wr(CDVAL_ADDR, 16'h0005);
        pulse(2);
        width(11000, CYC_4096);
        clr(16'h0002, 1'b1);
        wr(CTRL_ADDR, 16'h0480);
        pulse(6);
        see(1'b0);
        chk("timestamp", timestamp, 48'hA1B2C3D4E5F6);
        @(posedge ref_clk);
        time_now <= 48'h0F1E2D3C4B5A;
        pulse(6);
        tamper();
        rd(FLAGS_ADDR, 16'h0030);
        chk("timestamp", timestamp, 48'hA1B2C3D4E5F6);
        clr(16'h0030, 1'b1);
        wr(CTRL_ADDR, 16'h0080);
        pulse(6);
        see(1'b0);
        chk("timestamp", timestamp, 48'hA1B2C3D4E5F6);
        clr(16'h0020, 1'b1);
        wr(CTRL_ADDR, 16'h0040);
        tamper();
        see(1'b0);
        chk("timestamp", timestamp, 48'h0F1E2D3C4B5A);
        rd(FLAGS_ADDR, 16'h0008);
        clr(16'h0018, 1'b1);
        wr(CTRL_ADDR, 16'h0008);
        pulse(4);
        see(1'b0);
        clr(16'h0040, 1'b0);
        pulse(5);
        see(1'b1);
        wr(CTRL_ADDR, 16'h0100);
        @(posedge ref_clk);
        lbd <= 1'b1;
        @(posedge ref_clk);
        see(1'b0);
        rd(FLAGS_ADDR, 16'h0080);
        clr(16'h0080, 1'b0);
        wr(CTRL_ADDR, 16'h0000);
        see(1'b1);
        wr(CTRL_ADDR, 16'h0100);
        @(posedge ref_clk);
        lbd <= 1'b0;
        @(posedge ref_clk);
        see(1'b1);
        wr(CTRL_ADDR, 16'h0000);
        pulse(3);
        pulse(6);
        see(1'b1);
        wr(CTRL_ADDR, 16'h00A0);
        see(1'b0);
        clr(16'h0004, 1'b0);
        clr(16'h0020, 1'b1);
        close_out();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        close_out();
    end
endmodule
bind rtc_irq_out rtc_irq_out_sva i_rtc_irq_out_sva (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .sec_inc, .min_inc, .alarm_event,
    .watchdog_restart, .switchover_event, .tamper_in_n, .low_battery_detect, .time_now,
    .timestamp, .irq_oe
);
